// [src/ima_irq_indirect.sv]
// Interrupt enables, pending flags and indirect register access port behind an AHB-Lite slave
// Function
// - Enable bit zero masks, one passes
// - First enable: ring inactive 5, active 4
// - First enable: oscillator B inactive 3, active 2
// - First enable: oscillator A inactive 1, active 0
// - First enable bits 7:6 plain storage
// - Second enable bits 7:2 power alarms
// - Second enable: loop closure 1, ring trip 0
// - Third enable: done bit 1, 7:2 zero
// - Sixteen bit data split low/high bytes
// - Eight bit address register, read/write
// - Data then address write stores at tick
// - Address write alone loads data at tick
// - Completion sets done flag, write one clears
// - Busy status bit 0 while access pending
// - Pending flags clear on written one
//
// The AHB-Lite interface to the registers was left to the implementer.
`timescale 1ns/100ps
module ima_irq_indirect #(
  parameter int TICK_CYCLES = ima_pkg::TICK_CYC,
  parameter int DEPTH = ima_pkg::IND_DEPTH
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic [ima_pkg::EV1_W-1:0] evt_tone_ring,
  input wire logic [ima_pkg::EV2_W-1:0] evt_alarm_loop,
  output logic irq
);
  import ima_pkg::*;
  // Counter sized from the period, so a longer tick cannot wrap early
  localparam int CNT_W = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;

  logic addr_ok;
  logic [5:0] aidx;
  logic wr_q;
  logic [5:0] widx_q;
  logic [7:0] wdat;
  logic wr_stat1, wr_stat2, wr_stat3, wr_en1, wr_en2, wr_en3, wr_dlo, wr_dhi, wr_addr;
  logic [7:0] en1_q, en2_q, dlo_q, dhi_q, addr_q;
  logic [1:0] en3_q;
  logic [EV1_W-1:0] pend1_q;
  logic [EV2_W-1:0] pend2_q;
  logic pend3_q;
  logic busy_q, dload_q;
  logic [CNT_W-1:0] tick_cnt_q;
  logic tick, done;
  logic [15:0] mem_rd;
  logic [15:0] ind_mem [0:DEPTH-1];
  logic [7:0] rd_d;
  logic [31:0] hrdata_q;
  logic irq_d, irq_q;
  // Named enable fields and indirect port views
  logic ring_inactive_timer_irq_en;
  logic ring_active_timer_irq_en;
  logic tone_osc_b_inactive_irq_en;
  logic tone_osc_b_active_irq_en;
  logic tone_osc_a_inactive_irq_en;
  logic tone_osc_a_active_irq_en;
  logic power_alarm_six_irq_en;
  logic power_alarm_five_irq_en;
  logic power_alarm_four_irq_en;
  logic power_alarm_three_irq_en;
  logic power_alarm_two_irq_en;
  logic power_alarm_one_irq_en;
  logic loop_closure_irq_en;
  logic ring_trip_irq_en;
  logic indirect_done_irq_en;
  logic indirect_done_pending;
  logic [15:0] indirect_data_word;
  logic [7:0] indirect_target_address;
  logic indirect_busy_status;

  function automatic logic is_wr(input logic wr, input logic [5:0] idx, input logic [5:0] want);
    is_wr = wr && (idx == want);
  endfunction

  // Zero wait states; every transfer completes OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign addr_ok = hsel && htrans[1] && hready;
  assign aidx = (haddr[31:8] == 24'h0) ? haddr[7:2] : IDX_NONE;
  assign wdat = hwdata[7:0];

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_q <= 1'b0;
      widx_q <= IDX_NONE;
    end else begin
      wr_q <= addr_ok && hwrite;
      if (addr_ok) begin
        widx_q <= aidx;
      end
    end
  end

  assign wr_stat1 = is_wr(wr_q, widx_q, IDX_STAT1);
  assign wr_stat2 = is_wr(wr_q, widx_q, IDX_STAT2);
  assign wr_stat3 = is_wr(wr_q, widx_q, IDX_STAT3);
  assign wr_en1 = is_wr(wr_q, widx_q, IDX_EN1);
  assign wr_en2 = is_wr(wr_q, widx_q, IDX_EN2);
  assign wr_en3 = is_wr(wr_q, widx_q, IDX_EN3);
  assign wr_dlo = is_wr(wr_q, widx_q, IDX_DLO);
  assign wr_dhi = is_wr(wr_q, widx_q, IDX_DHI);
  assign wr_addr = is_wr(wr_q, widx_q, IDX_ADDR);

  // Enable registers
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      en1_q <= EN1_RST;
      en2_q <= EN2_RST;
      en3_q <= EN3_RST;
    end else begin
      if (wr_en1) begin
        en1_q <= wdat;
      end
      if (wr_en2) begin
        en2_q <= wdat;
      end
      if (wr_en3) begin
        en3_q <= wdat[1:0];
      end
    end
  end

  // Pending flags; an event in the clearing cycle survives
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      pend1_q <= '0;
      pend2_q <= '0;
      pend3_q <= 1'b0;
    end else begin
      pend1_q <= (pend1_q & ~(wr_stat1 ? wdat[EV1_W-1:0] : '0)) | evt_tone_ring;
      pend2_q <= (pend2_q & ~(wr_stat2 ? wdat : 8'h00)) | evt_alarm_loop;
      pend3_q <= (pend3_q & ~(wr_stat3 && wdat[BIT_IND_DONE])) | done;
    end
  end

  // Enable fields by name
  assign ring_inactive_timer_irq_en = en1_q[BIT_RING_INACT];
  assign ring_active_timer_irq_en = en1_q[BIT_RING_ACT];
  assign tone_osc_b_inactive_irq_en = en1_q[BIT_OSC_B_INACT];
  assign tone_osc_b_active_irq_en = en1_q[BIT_OSC_B_ACT];
  assign tone_osc_a_inactive_irq_en = en1_q[BIT_OSC_A_INACT];
  assign tone_osc_a_active_irq_en = en1_q[BIT_OSC_A_ACT];
  assign power_alarm_six_irq_en = en2_q[BIT_ALARM_LO + 5];
  assign power_alarm_five_irq_en = en2_q[BIT_ALARM_LO + 4];
  assign power_alarm_four_irq_en = en2_q[BIT_ALARM_LO + 3];
  assign power_alarm_three_irq_en = en2_q[BIT_ALARM_LO + 2];
  assign power_alarm_two_irq_en = en2_q[BIT_ALARM_LO + 1];
  assign power_alarm_one_irq_en = en2_q[BIT_ALARM_LO];
  assign loop_closure_irq_en = en2_q[BIT_LOOP_CLOSE];
  assign ring_trip_irq_en = en2_q[BIT_RING_TRIP];
  assign indirect_done_irq_en = en3_q[BIT_IND_DONE];
  assign indirect_done_pending = pend3_q;
  assign indirect_data_word = {dhi_q, dlo_q};
  assign indirect_target_address = addr_q;
  assign indirect_busy_status = busy_q;

  // Masked flags still record, they only stay off the output
  assign irq_d = (pend1_q[BIT_RING_INACT] && ring_inactive_timer_irq_en)
    || (pend1_q[BIT_RING_ACT] && ring_active_timer_irq_en)
    || (pend1_q[BIT_OSC_B_INACT] && tone_osc_b_inactive_irq_en)
    || (pend1_q[BIT_OSC_B_ACT] && tone_osc_b_active_irq_en)
    || (pend1_q[BIT_OSC_A_INACT] && tone_osc_a_inactive_irq_en)
    || (pend1_q[BIT_OSC_A_ACT] && tone_osc_a_active_irq_en)
    || (pend2_q[BIT_ALARM_LO + 5] && power_alarm_six_irq_en)
    || (pend2_q[BIT_ALARM_LO + 4] && power_alarm_five_irq_en)
    || (pend2_q[BIT_ALARM_LO + 3] && power_alarm_four_irq_en)
    || (pend2_q[BIT_ALARM_LO + 2] && power_alarm_three_irq_en)
    || (pend2_q[BIT_ALARM_LO + 1] && power_alarm_two_irq_en)
    || (pend2_q[BIT_ALARM_LO] && power_alarm_one_irq_en)
    || (pend2_q[BIT_LOOP_CLOSE] && loop_closure_irq_en)
    || (pend2_q[BIT_RING_TRIP] && ring_trip_irq_en)
    || (indirect_done_pending && indirect_done_irq_en);

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= irq_d;
    end
  end
  assign irq = irq_q;

  // Indirect update tick, free running
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      tick_cnt_q <= '0;
    end else if (tick) begin
      tick_cnt_q <= '0;
    end else begin
      tick_cnt_q <= tick_cnt_q + 1'b1;
    end
  end
  assign tick = (tick_cnt_q == CNT_W'(TICK_CYCLES - 1));
  // An address write in the tick cycle waits for the next tick
  assign done = tick && busy_q && !wr_addr;

  // Request tracking; rewrites while busy are not blocked
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      busy_q <= 1'b0;
      dload_q <= 1'b0;
    end else begin
      if (wr_addr) begin
        busy_q <= 1'b1;
      end else if (done) begin
        busy_q <= 1'b0;
      end
      if (wr_dlo || wr_dhi) begin
        dload_q <= 1'b1;
      end else if (done) begin
        dload_q <= 1'b0;
      end
    end
  end

  // Address reset value is nominally undefined; zero here
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      addr_q <= ADDR_RST;
    end else if (wr_addr) begin
      addr_q <= wdat;
    end
  end

  assign mem_rd = ind_mem[indirect_target_address];

  // Data pair; software write wins over a read completion
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      dlo_q <= DATA_RST;
      dhi_q <= DATA_RST;
    end else begin
      if (wr_dlo) begin
        dlo_q <= wdat;
      end else if (done && !dload_q) begin
        dlo_q <= mem_rd[7:0];
      end
      if (wr_dhi) begin
        dhi_q <= wdat;
      end else if (done && !dload_q) begin
        dhi_q <= mem_rd[15:8];
      end
    end
  end

  // Array holds no reset; unwritten entries read unknown
  always_ff @(posedge sys_clk) begin
    if (done && dload_q) begin
      ind_mem[indirect_target_address] <= indirect_data_word;
    end
  end

  // Read mux, sampled at the address phase
  always_comb begin
    rd_d = 8'h00;
    case (aidx)
      IDX_STAT1: rd_d = {2'b00, pend1_q};
      IDX_STAT2: rd_d = pend2_q;
      IDX_STAT3: rd_d = {6'h00, pend3_q, 1'b0};
      IDX_EN1: rd_d = en1_q;
      IDX_EN2: rd_d = en2_q;
      IDX_EN3: rd_d = {6'h00, en3_q};
      IDX_DLO: rd_d = dlo_q;
      IDX_DHI: rd_d = dhi_q;
      IDX_ADDR: rd_d = addr_q;
      IDX_BUSY: rd_d = {7'h00, indirect_busy_status};
      default: rd_d = 8'h00;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      hrdata_q <= 32'h0;
    end else if (addr_ok && !hwrite) begin
      hrdata_q <= {24'h0, rd_d};
    end
  end
  assign hrdata = hrdata_q;

  property p_irq_masked;
    @(posedge sys_clk) disable iff (!rst_b)
    (((pend1_q & en1_q[EV1_W-1:0]) == '0) && ((pend2_q & en2_q) == 8'h00) && !(pend3_q && en3_q[1])) |=> !irq;
  endproperty
  a_irq_masked: assert property (p_irq_masked) else $error("irq high with all sources masked");

  property p_irq_raised;
    @(posedge sys_clk) disable iff (!rst_b)
    (pend2_q[BIT_RING_TRIP] && en2_q[BIT_RING_TRIP]) |=> irq;
  endproperty
  a_irq_raised: assert property (p_irq_raised) else $error("irq low with enabled flag pending");

  property p_event_sets;
    @(posedge sys_clk) disable iff (!rst_b)
    evt_tone_ring[BIT_OSC_A_ACT] |=> pend1_q[BIT_OSC_A_ACT] ##1 (pend1_q[BIT_OSC_A_ACT] || $past(wr_stat1));
  endproperty
  a_event_sets: assert property (p_event_sets) else $error("event lost from pending flag");

  property p_w1c;
    @(posedge sys_clk) disable iff (!rst_b)
    (wr_stat2 && wdat[BIT_LOOP_CLOSE] && !evt_alarm_loop[BIT_LOOP_CLOSE]) |=> !pend2_q[BIT_LOOP_CLOSE];
  endproperty
  a_w1c: assert property (p_w1c) else $error("pending flag not cleared by one");

  property p_busy_set;
    @(posedge sys_clk) disable iff (!rst_b)
    wr_addr |=> busy_q && (addr_q == $past(wdat));
  endproperty
  a_busy_set: assert property (p_busy_set) else $error("address write did not start access");

  property p_done;
    @(posedge sys_clk) disable iff (!rst_b)
    (tick && busy_q && !wr_addr) |=> !busy_q && pend3_q;
  endproperty
  a_done: assert property (p_done) else $error("access not completed at tick");

  property p_store;
    @(posedge sys_clk) disable iff (!rst_b)
    (done && dload_q) |=> ind_mem[$past(addr_q)] == $past({dhi_q, dlo_q});
  endproperty
  a_store: assert property (p_store) else $error("indirect write not stored");

  property p_load;
    @(posedge sys_clk) disable iff (!rst_b)
    (done && !dload_q && !wr_dlo && !wr_dhi) |=> {dhi_q, dlo_q} == $past(mem_rd);
  endproperty
  a_load: assert property (p_load) else $error("indirect read not loaded");

  property p_busy_hold;
    @(posedge sys_clk) disable iff (!rst_b)
    (busy_q && !tick) |=> busy_q;
  endproperty
  a_busy_hold: assert property (p_busy_hold) else $error("busy dropped between ticks");

  property p_en3_zero;
    @(posedge sys_clk) disable iff (!rst_b)
    (addr_ok && !hwrite && aidx == IDX_EN3) |=> hrdata[7:2] == 6'h00;
  endproperty
  a_en3_zero: assert property (p_en3_zero) else $error("reserved enable bits read nonzero");

  property p_en1_write;
    @(posedge sys_clk) disable iff (!rst_b)
    wr_en1 |=> en1_q == $past(wdat);
  endproperty
  a_en1_write: assert property (p_en1_write) else $error("first enable write not stored");

  property p_addr_hold;
    @(posedge sys_clk) disable iff (!rst_b)
    !wr_addr |=> $stable(addr_q);
  endproperty
  a_addr_hold: assert property (p_addr_hold) else $error("address changed without a write");

  property p_busy_read;
    @(posedge sys_clk) disable iff (!rst_b)
    (addr_ok && !hwrite && aidx == IDX_BUSY) |=> hrdata == {31'h0, $past(busy_q)};
  endproperty
  a_busy_read: assert property (p_busy_read) else $error("busy status read wrong");

  property p_masked_record;
    @(posedge sys_clk) disable iff (!rst_b)
    evt_alarm_loop[BIT_RING_TRIP] |=> pend2_q[BIT_RING_TRIP];
  endproperty
  a_masked_record: assert property (p_masked_record) else $error("event not recorded");

  property p_set_wins;
    @(posedge sys_clk) disable iff (!rst_b)
    (wr_stat2 && evt_alarm_loop[BIT_LOOP_CLOSE]) |=> pend2_q[BIT_LOOP_CLOSE];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("clear won over event");
endmodule // ima_irq_indirect

// [src/ima_pkg.sv]
// Register map, field positions and timing constants of the interrupt enable and indirect access block
package ima_pkg;
  // Word indices; byte address is four times the index
  localparam logic [5:0] IDX_NONE = 6'h00;
  localparam logic [5:0] IDX_STAT1 = 6'h12;
  localparam logic [5:0] IDX_STAT2 = 6'h13;
  localparam logic [5:0] IDX_STAT3 = 6'h14;
  localparam logic [5:0] IDX_EN1 = 6'h15;
  localparam logic [5:0] IDX_EN2 = 6'h16;
  localparam logic [5:0] IDX_EN3 = 6'h17;
  localparam logic [5:0] IDX_DLO = 6'h1c;
  localparam logic [5:0] IDX_DHI = 6'h1d;
  localparam logic [5:0] IDX_ADDR = 6'h1e;
  localparam logic [5:0] IDX_BUSY = 6'h1f;
  // First enable and pending register fields
  localparam int BIT_RING_INACT = 5;
  localparam int BIT_RING_ACT = 4;
  localparam int BIT_OSC_B_INACT = 3;
  localparam int BIT_OSC_B_ACT = 2;
  localparam int BIT_OSC_A_INACT = 1;
  localparam int BIT_OSC_A_ACT = 0;
  localparam int EV1_W = 6;
  // Second register: alarms six..one at 7..2, loop closure 1, ring trip 0
  localparam int BIT_ALARM_LO = 2;
  localparam int BIT_LOOP_CLOSE = 1;
  localparam int BIT_RING_TRIP = 0;
  localparam int EV2_W = 8;
  // Third register and busy status
  localparam int BIT_IND_DONE = 1;
  localparam int BIT_EN3_SPARE = 0;
  localparam int BIT_BUSY = 0;
  // Reset values
  localparam logic [7:0] EN1_RST = 8'h00;
  localparam logic [7:0] EN2_RST = 8'h00;
  localparam logic [1:0] EN3_RST = 2'h0;
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam logic [7:0] ADDR_RST = 8'h00;
  // Indirect update tick
  localparam int CLK_HZ = 50_000_000;
  localparam int TICK_HZ = 16_000;
  localparam int TICK_CYC = CLK_HZ / TICK_HZ;
  localparam int TICK_W = 12;
  localparam int IND_DEPTH = 256;
endpackage

// [verif/tb_top.sv]
// Self-checking bench for the interrupt enable and indirect access block
`timescale 1ns/100ps
module tb_top;
  import ima_pkg::*;
  // Short tick keeps indirect waits to a few cycles
  localparam int TICK = 8;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [5:0] evt_tone_ring = 6'h00;
  logic [7:0] evt_alarm_loop = 8'h00;
  logic hreadyout;
  logic hresp;
  logic irq;
  logic [31:0] hrdata;
  logic [7:0] rv;
  int failures = 0;
  int compares = 0;
  always #10 sys_clk = ~sys_clk;
  ima_irq_indirect #(.TICK_CYCLES(TICK), .DEPTH(IND_DEPTH)) dut (.sys_clk(sys_clk), .rst_b(rst_b),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .evt_tone_ring(evt_tone_ring), .evt_alarm_loop(evt_alarm_loop), .irq(irq));
  task automatic test_done;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Bounded wait for the slave's ready at a rising edge
  task automatic rdy;
    int n;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (hreadyout !== 1'b1) begin
      failures++;
      $display("[ERR] hready expected 1 seen %b", hreadyout);
      test_done;
    end
  endtask
  task automatic xfer(input logic [5:0] idx, input logic wr, input logic [7:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, idx, 2'b00};
    htrans <= 2'h2;
    hwrite <= wr;
    rdy;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    rdy;
    rv = hrdata[7:0];
    chk("hresp", 8'h00, {7'h0, hresp});
  endtask
  task automatic rd(input logic [5:0] idx, input logic [7:0] exp, input string nm);
    xfer(idx, 1'b0, 8'h00);
    chk(nm, exp, rv);
    chk("hrdata upper", 8'h00, hrdata[31:24] | hrdata[23:16] | hrdata[15:8]);
  endtask
  // One event source: masked, then enabled, then cleared
  task automatic evt(input int r, input int b);
    logic [5:0] idx;
    logic [7:0] m;
    idx = (r == 1) ? IDX_EN1 : IDX_EN2;
    m = 8'h01 << b;
    if (r == 1) begin
      evt_tone_ring <= m[5:0];
    end else begin
      evt_alarm_loop <= m;
    end
    @(posedge sys_clk);
    evt_tone_ring <= 6'h00;
    evt_alarm_loop <= 8'h00;
    repeat (3) @(posedge sys_clk);
    chk("irq masked", 8'h00, {7'h0, irq});
    rd(idx - 6'h03, m, "pending");
    xfer(idx, 1'b1, m);
    repeat (2) @(posedge sys_clk);
    chk("irq enabled", 8'h01, {7'h0, irq});
    xfer(idx - 6'h03, 1'b1, ~m);
    rd(idx - 6'h03, m, "pending kept");
    xfer(idx - 6'h03, 1'b1, m);
    repeat (2) @(posedge sys_clk);
    chk("irq cleared", 8'h00, {7'h0, irq});
    rd(idx - 6'h03, 8'h00, "pending cleared");
    xfer(idx, 1'b1, 8'h00);
  endtask
  // Indirect access; data bytes written first make it a store
  task automatic ind(input logic [7:0] a, input logic w, input logic [15:0] d);
    int n;
    if (w) begin
      xfer(IDX_DLO, 1'b1, d[7:0]);
      xfer(IDX_DHI, 1'b1, d[15:8]);
    end
    xfer(IDX_ADDR, 1'b1, a);
    rd(IDX_BUSY, 8'h01, "busy");
    n = 0;
    // Registers are rewritten only once busy reads clear
    do begin
      xfer(IDX_BUSY, 1'b0, 8'h00);
      n++;
    end while (rv !== 8'h00 && n < 4 * TICK);
    chk("busy idle", 8'h00, rv);
    if (rv !== 8'h00) begin
      test_done;
    end
    rd(IDX_STAT3, 8'h02, "done flag");
    chk("irq done", 8'h01, {7'h0, irq});
    xfer(IDX_STAT3, 1'b1, 8'h02);
    rd(IDX_STAT3, 8'h00, "done cleared");
  endtask
  initial begin
    #1_000_000;
    failures++;
    $display("[ERR] run limit expected done seen running");
    test_done;
  end
  initial begin
    repeat (20) @(posedge sys_clk);
    rst_b <= 1'b1;
    @(posedge sys_clk);
    chk("irq reset", 8'h00, {7'h0, irq});
    rd(IDX_EN3, 8'h00, "en3 reset");
    rd(IDX_DLO, 8'h00, "data low reset");
    rd(IDX_BUSY, 8'h00, "busy reset");
    xfer(IDX_EN1, 1'b1, 8'hff);
    rd(IDX_EN1, 8'hff, "en1");
    xfer(IDX_EN2, 1'b1, 8'hff);
    rd(IDX_EN2, 8'hff, "en2");
    xfer(IDX_EN3, 1'b1, 8'hff);
    rd(IDX_EN3, 8'h03, "en3");
    chk("irq no pending", 8'h00, {7'h0, irq});
    xfer(IDX_EN1, 1'b1, 8'hc0);
    rd(IDX_EN1, 8'hc0, "en1 spare");
    xfer(IDX_EN1, 1'b1, 8'h00);
    xfer(IDX_EN2, 1'b1, 8'h00);
    xfer(IDX_EN3, 1'b1, 8'h01);
    rd(IDX_EN3, 8'h01, "en3 spare");
    xfer(IDX_DHI, 1'b1, 8'ha5);
    rd(IDX_DHI, 8'ha5, "data high");
    xfer(6'h20, 1'b1, 8'hff);
    rd(6'h20, 8'h00, "unmapped");
    for (int b = 0; b < EV1_W; b++) begin
      evt(1, b);
    end
    for (int b = 0; b < EV2_W; b++) begin
      evt(2, b);
    end
    // Event held through the clearing write; the set must win
    evt_alarm_loop <= 8'h02;
    xfer(IDX_STAT2, 1'b1, 8'h02);
    evt_alarm_loop <= 8'h00;
    rd(IDX_STAT2, 8'h02, "set wins");
    xfer(IDX_STAT2, 1'b1, 8'h02);
    rd(IDX_STAT2, 8'h00, "set wins cleared");
    xfer(IDX_EN3, 1'b1, 8'h02);
    ind(8'h05, 1'b1, 16'h1234);
    ind(8'h06, 1'b1, 16'habcd);
    rd(IDX_ADDR, 8'h06, "address");
    ind(8'h05, 1'b0, 16'h0000);
    rd(IDX_DLO, 8'h34, "read low");
    rd(IDX_DHI, 8'h12, "read high");
    ind(8'h06, 1'b0, 16'h0000);
    rd(IDX_DLO, 8'hcd, "stored low");
    rd(IDX_DHI, 8'hab, "stored high");
    test_done;
  end
endmodule // tb_top
